// ---- common/iplr_pkg.sv ----
// Package of constants for the interrupt priority level registers.
package iplr_pkg;

    // Bus and source geometry.
    localparam int          IPLR_AW       = 12;
    localparam int          IPLR_NSRC     = 7;

    // Register indexes as numbered in the special-function space.
    localparam logic [7:0]  IDX_PRIO_HI   = 8'hB7;
    localparam logic [7:0]  IDX_PRIO_LO   = 8'hB8;

    // Byte addresses on the bus: four times the index.
    localparam logic [IPLR_AW-1:0] ADDR_PRIO_HI = {2'h0, IDX_PRIO_HI, 2'h0};
    localparam logic [IPLR_AW-1:0] ADDR_PRIO_LO = {2'h0, IDX_PRIO_LO, 2'h0};
    // Write-one aliases that set or clear single bits of the low register.
    localparam logic [IPLR_AW-1:0] ADDR_LO_SET  = 12'h300;
    localparam logic [IPLR_AW-1:0] ADDR_LO_CLR  = 12'h304;

    // Reset values of the implemented bits 6..0.
    localparam logic [6:0]  RST_PRIO_HI   = 7'h00;
    localparam logic [6:0]  RST_PRIO_LO   = 7'h00;

    // Bit position of each source in both registers.
    localparam int          SRC_EXT_INPUT0   = 0;
    localparam int          SRC_TIMER0       = 1;
    localparam int          SRC_EXT_INPUT1   = 2;
    localparam int          SRC_TIMER1       = 3;
    localparam int          SRC_SERIAL       = 4;
    localparam int          SRC_TIMER2       = 5;
    localparam int          SRC_COUNTER_ARR  = 6;

    // Bus responses.
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage

// ---- dv/iplr_seq_model.sv ----
// Behavioural interrupt sequencer facing the priority level block.
`timescale 1ns/10ps
`default_nettype none
module iplr_seq_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Commands from the bench
    input  wire logic [6:0] want,
    input  wire logic       take,
    input  wire logic       ret,
    // Block side
    input  wire logic       irq_valid,
    output var  logic [6:0] irq_req,
    output var  logic       irq_ack,
    output var  logic       irq_reti
);
    // The core only acknowledges a choice that is on offer, so a take is
    // dropped when nothing is valid rather than sent blindly.
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_req <= 7'h00;
            irq_ack <= 1'b0;
            irq_reti <= 1'b0;
        end else begin
            irq_req <= want;
            irq_ack <= take & irq_valid;
            irq_reti <= ret;
        end
    end
endmodule
`default_nettype wire

// ---- dv/test_irq_priority_low_regs.sv ----
// Bench for the priority level registers and their level arbiter.
`timescale 1ns/10ps
`default_nettype none
module test_irq_priority_low_regs;
    import iplr_pkg::*;
    logic        clk = 0, rst = 1, take = 0, ret = 0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0]  wstrb = '0;
    logic [6:0]  want = '0, req;
    logic        awready, wready, bvalid, arready, rvalid, ivalid, ack, reti;
    logic [1:0]  bresp, rresp;
    logic [13:0] levels;
    logic [2:0]  sel;
    int          n_errors = 0, cmp_count = 0;
    always #2.5 clk = ~clk;
    iplr_regs dut (.SYS_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .IRQ_REQ(req), .IRQ_ACK(ack), .IRQ_RETI(reti),
        .IRQ_LEVELS(levels), .IRQ_VALID(ivalid), .IRQ_SEL(sel));
    iplr_seq_model seq (.clk(clk), .rst(rst), .want(want), .take(take), .ret(ret),
        .irq_valid(ivalid), .irq_req(req), .irq_ack(ack), .irq_reti(reti));
    ////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bound(input int n);
        if (n >= 50) begin
            n_errors++;
            results();
        end
    endtask
    // Each channel is released only at the edge that takes it.
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (!(bvalid && bready) && n < 50);
        bready <= 0;
        bound(n);
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 0;
        end while (!(rvalid && rready) && n < 50);
        rready <= 0;
        bound(n);
        chk(rdata, ed);
        chk(32'(rresp), 32'(er));
    endtask
    // Outputs lag requests by two registers, so five edges is ample.
    task automatic irq(input logic [6:0] w, input logic t, input logic r,
                       input logic v, input logic [2:0] s);
        @(posedge clk);
        want <= w;
        take <= t;
        ret <= r;
        @(posedge clk);
        take <= 0;
        ret <= 0;
        repeat (5) @(posedge clk);
        chk(32'(ivalid), 32'(v));
        if (v) chk(32'(sel), 32'(s));
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clk);
        rst <= 0;
        rd(ADDR_PRIO_HI, 32'h0, RESP_OKAY);
        rd(ADDR_PRIO_LO, 32'h0, RESP_OKAY);
        wr(12'h010, 32'h7F, 4'h1, RESP_SLVERR);
        wr(ADDR_PRIO_HI, 32'h0C, 4'h1, RESP_OKAY);
        wr(ADDR_PRIO_LO, 32'h0A, 4'hF, RESP_OKAY);
        wr(ADDR_PRIO_HI, 32'h7F, 4'hE, RESP_OKAY);
        rd(ADDR_PRIO_HI, 32'h0C, RESP_OKAY);
        rd(ADDR_PRIO_LO, 32'h0A, RESP_OKAY);
        chk(32'(levels), 32'h0000_00E4);
        irq(7'h03, 1'b0, 1'b0, 1'b1, 3'h1);
        irq(7'h41, 1'b0, 1'b0, 1'b1, 3'h0);
        irq(7'h41, 1'b1, 1'b0, 1'b0, 3'h0);
        irq(7'h43, 1'b0, 1'b0, 1'b1, 3'h1);
        irq(7'h43, 1'b1, 1'b0, 1'b0, 3'h0);
        irq(7'h4F, 1'b0, 1'b0, 1'b1, 3'h3);
        irq(7'h4F, 1'b1, 1'b0, 1'b0, 3'h0);
        irq(7'h47, 1'b0, 1'b0, 1'b0, 3'h0);
        irq(7'h47, 1'b0, 1'b1, 1'b1, 3'h2);
        irq(7'h00, 1'b0, 1'b1, 1'b0, 3'h0);
        irq(7'h00, 1'b0, 1'b1, 1'b0, 3'h0);
        irq(7'h41, 1'b0, 1'b0, 1'b1, 3'h0);
        wr(ADDR_LO_SET, 32'h40, 4'h1, RESP_OKAY);
        rd(ADDR_PRIO_LO, 32'h4A, RESP_OKAY);
        wr(ADDR_LO_CLR, 32'h0A, 4'h1, RESP_OKAY);
        rd(ADDR_PRIO_LO, 32'h40, RESP_OKAY);
        chk(32'(levels), 32'h0000_10A0);
        wr(ADDR_PRIO_HI, 32'h7F, 4'h1, RESP_OKAY);
        rd(ADDR_PRIO_HI, 32'h7F, RESP_OKAY);
        @(posedge clk);
        rst <= 1;
        repeat (2) @(posedge clk);
        rst <= 0;
        rd(ADDR_PRIO_HI, 32'h0, RESP_OKAY);
        rd(ADDR_PRIO_LO, 32'h0, RESP_OKAY);
        results();
    end
endmodule
`default_nettype wire

// ---- rtl/iplr_regs.sv ----
// Interrupt priority level registers with AXI4-Lite access and level arbiter.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Low priority register decoded at index B8h for reads and writes.
// - Low register bits 6..0 reset to zero; single-bit set and clear allowed.
// - High priority register decoded at index B7h for reads and writes.
// - High register bits 6..0 reset to zero; only whole-byte writes accepted.
// - Bit 7 reserved in both registers; software never writes one there.
// - Bits 6..0 map to counter array, timer2, serial, timer1, ext1, timer0, ext0.
// - Each source level joins its low and high bit at the same position.
// - High bit is level MSB; zero lowest, three highest of four levels.
// - Service is preempted only by strictly higher level; level three never.
// - Simultaneous requests: highest level wins, ties by fixed polling order.
module iplr_regs (
    // Clock and reset
    input  wire logic                           SYS_CLK,
    input  wire logic                           RST,
    // AXI4-Lite write address
    input  wire logic [iplr_pkg::IPLR_AW-1:0]   S_AXI_AWADDR,
    input  wire logic                           S_AXI_AWVALID,
    output var  logic                           S_AXI_AWREADY,
    // AXI4-Lite write data
    input  wire logic [31:0]                    S_AXI_WDATA,
    input  wire logic [3:0]                     S_AXI_WSTRB,
    input  wire logic                           S_AXI_WVALID,
    output var  logic                           S_AXI_WREADY,
    // AXI4-Lite write response
    output var  logic [1:0]                     S_AXI_BRESP,
    output var  logic                           S_AXI_BVALID,
    input  wire logic                           S_AXI_BREADY,
    // AXI4-Lite read address
    input  wire logic [iplr_pkg::IPLR_AW-1:0]   S_AXI_ARADDR,
    input  wire logic                           S_AXI_ARVALID,
    output var  logic                           S_AXI_ARREADY,
    // AXI4-Lite read data
    output var  logic [31:0]                    S_AXI_RDATA,
    output var  logic [1:0]                     S_AXI_RRESP,
    output var  logic                           S_AXI_RVALID,
    input  wire logic                           S_AXI_RREADY,
    // Interrupt sequencer side
    input  wire logic [iplr_pkg::IPLR_NSRC-1:0] IRQ_REQ,
    input  wire logic                           IRQ_ACK,
    input  wire logic                           IRQ_RETI,
    output var  logic [2*iplr_pkg::IPLR_NSRC-1:0] IRQ_LEVELS,
    output var  logic                           IRQ_VALID,
    output var  logic [2:0]                     IRQ_SEL
);
    import iplr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    logic                  aw_have_q;
    logic                  w_have_q;
    logic                  aw_have_d;
    logic                  w_have_d;
    logic                  rvalid_d;
    logic [IPLR_AW-1:0]    awaddr_q;
    logic [31:0]           wdata_q;
    logic [3:0]            wstrb_q;
    logic [6:0]            lo_q;
    logic [6:0]            hi_q;
    logic [6:0]            lo_d;
    logic [6:0]            hi_d;
    logic [3:0]            in_svc_q;
    logic [3:0]            in_svc_d;
    logic [1:0]            sel_lvl_q;

    wire aw_take  = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_take   = S_AXI_WVALID && S_AXI_WREADY;
    wire ar_take  = S_AXI_ARVALID && S_AXI_ARREADY;
    wire wr_fire  = aw_have_q && w_have_q && !S_AXI_BVALID;
    wire wr_lo    = (awaddr_q == ADDR_PRIO_LO);
    wire wr_hi    = (awaddr_q == ADDR_PRIO_HI);
    wire wr_set   = (awaddr_q == ADDR_LO_SET);
    wire wr_clr   = (awaddr_q == ADDR_LO_CLR);
    wire wr_map   = wr_lo || wr_hi || wr_set || wr_clr;
    // Only lane 0 carries the byte; a write without it changes nothing.
    wire wr_byte  = wr_fire && wstrb_q[0];
    wire [6:0] wbits = wdata_q[6:0];

    wire rd_lo    = (S_AXI_ARADDR == ADDR_PRIO_LO) || (S_AXI_ARADDR == ADDR_LO_SET)
                    || (S_AXI_ARADDR == ADDR_LO_CLR);
    wire rd_hi    = (S_AXI_ARADDR == ADDR_PRIO_HI);
    wire [6:0] rd_bits = rd_lo ? lo_q : (rd_hi ? hi_q : 7'h00);

    assign aw_have_d = aw_take ? 1'b1 : (wr_fire ? 1'b0 : aw_have_q);
    assign w_have_d  = w_take ? 1'b1 : (wr_fire ? 1'b0 : w_have_q);
    assign rvalid_d  = ar_take ? 1'b1 : (S_AXI_RREADY ? 1'b0 : S_AXI_RVALID);

    // Bit 7 has no storage at all, so writes to it vanish.
    assign lo_d = !(wr_byte) ? lo_q :
                  wr_lo  ? wbits :
                  wr_set ? (lo_q | wbits) :
                  wr_clr ? (lo_q & ~wbits) : lo_q;
    // No alias exists for the high register: single-bit access is impossible.
    assign hi_d = (wr_byte && wr_hi) ? wbits : hi_q;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            awaddr_q      <= '0;
            wdata_q       <= 32'h0000_0000;
            wstrb_q       <= 4'h0;
        end else begin
            aw_have_q     <= aw_have_d;
            w_have_q      <= w_have_d;
            S_AXI_AWREADY <= !aw_have_d;
            S_AXI_WREADY  <= !w_have_d;
            if (aw_take) begin
                awaddr_q <= S_AXI_AWADDR;
            end
            if (w_take) begin
                wdata_q <= S_AXI_WDATA;
                wstrb_q <= S_AXI_WSTRB;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= RESP_OKAY;
        end else if (wr_fire) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= wr_map ? RESP_OKAY : RESP_SLVERR;
        end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= RESP_OKAY;
        end else begin
            S_AXI_ARREADY <= !rvalid_d;
            S_AXI_RVALID  <= rvalid_d;
            if (ar_take) begin
                S_AXI_RDATA <= {25'h0000000, rd_bits};
                S_AXI_RRESP <= (rd_lo || rd_hi) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            lo_q <= RST_PRIO_LO;
            hi_q <= RST_PRIO_HI;
        end else begin
            lo_q <= lo_d;
            hi_q <= hi_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    logic [1:0]            src_lvl [IPLR_NSRC];
    logic [IPLR_NSRC-1:0]  elig;
    logic [1:0]            act_lvl;
    logic                  any_act;
    logic                  cand_valid;
    logic [2:0]            cand_idx;
    logic [1:0]            cand_lvl;

    assign any_act = |in_svc_q;
    assign act_lvl = in_svc_q[3] ? 2'h3 : (in_svc_q[2] ? 2'h2 : (in_svc_q[1] ? 2'h1 : 2'h0));

    // Bit i of each register belongs to the same source, in fixed order.
    genvar g;
    for (g = 0; g < IPLR_NSRC; g++) begin : g_src
        assign src_lvl[g] = {hi_q[g], lo_q[g]};
        assign elig[g]    = IRQ_REQ[g] && (!any_act || src_lvl[g] > act_lvl);
    end

    // Scanning from the top with >= lets the lowest index win a tie.
    always_comb begin
        cand_valid = 1'b0;
        cand_idx   = 3'h0;
        cand_lvl   = 2'h0;
        for (int i = IPLR_NSRC - 1; i >= 0; i--) begin
            if (elig[i] && (!cand_valid || src_lvl[i] >= cand_lvl)) begin
                cand_valid = 1'b1;
                cand_idx   = 3'(i);
                cand_lvl   = src_lvl[i];
            end
        end
    end

    // A return closes the innermost level before a new acknowledge opens one.
    always_comb begin
        in_svc_d = in_svc_q;
        if (IRQ_RETI && any_act) begin
            in_svc_d[act_lvl] = 1'b0;
        end
        if (IRQ_ACK && IRQ_VALID) begin
            in_svc_d[sel_lvl_q] = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            in_svc_q   <= 4'h0;
            sel_lvl_q  <= 2'h0;
            IRQ_VALID  <= 1'b0;
            IRQ_SEL    <= 3'h0;
            IRQ_LEVELS <= '0;
        end else begin
            in_svc_q   <= in_svc_d;
            sel_lvl_q  <= cand_lvl;
            IRQ_VALID  <= cand_valid && !(IRQ_ACK && IRQ_VALID);
            IRQ_SEL    <= cand_idx;
            for (int i = 0; i < IPLR_NSRC; i++) begin
                IRQ_LEVELS[2*i +: 2] <= src_lvl[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    reset_clear_a: assert property ($past(RST) |-> (lo_q == 7'h00 && hi_q == 7'h00))
        else $error("priority registers not clear after reset");
    lo_write_a: assert property (wr_byte && wr_lo |=> lo_q == $past(wbits))
        else $error("low register write lost");
    hi_write_a: assert property (wr_byte && wr_hi |=> hi_q == $past(wbits))
        else $error("high register write lost");
    hi_only_a: assert property (!(wr_byte && wr_hi) |=> $stable(hi_q))
        else $error("high register changed without whole-byte write");
    lo_bitset_a: assert property (wr_byte && wr_set |=> lo_q == ($past(lo_q) | $past(wbits)))
        else $error("low register bit set wrong");
    rsvd_zero_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:7] == 25'h0)
        else $error("reserved read bits not zero");
    level_map_a: assert property (##1 IRQ_LEVELS[9:8] == $past({hi_q[4], lo_q[4]}))
        else $error("serial level not built from its bit pair");
    preempt_a: assert property (cand_valid && any_act |-> cand_lvl > act_lvl)
        else $error("preemption by equal or lower level");
    top_lvl_a: assert property (in_svc_q[3] |-> !cand_valid ##1 !IRQ_VALID)
        else $error("top level service was preempted");
    tie_pick_a: assert property (cand_valid |-> elig[cand_idx] &&
                                 !(elig[0] && src_lvl[0] == cand_lvl && cand_idx != 3'h0))
        else $error("arbiter pick breaks level or polling order");
    wr_resp_a: assert property (wr_fire |=> S_AXI_BVALID)
        else $error("write response missing");

    set_cov: cover property (wr_byte && wr_set);
    nest_cov: cover property (IRQ_ACK && IRQ_VALID && any_act);
    tie_cov: cover property (cand_valid && elig[0] && elig[1] && src_lvl[0] == src_lvl[1]);

endmodule

`default_nettype wire
